// *** htl_sensor.sv ***
// Sensor end of the single-wire link: start detection, response, 40-bit frame
`timescale 1ns/1ps
`default_nettype none
module htl_sensor
  import htl_pkg::*;
#(
  parameter logic [CNT_W-1:0] START_MIN = START_CNT,
  parameter logic [CNT_W-1:0] GAP_LEN = GAP_CNT,
  parameter logic [CNT_W-1:0] RESP_LEN = RESP_CNT,
  parameter logic [CNT_W-1:0] BIT_LOW_LEN = BIT_LOW_CNT,
  parameter logic [CNT_W-1:0] ZERO_HIGH_LEN = ZERO_HIGH_CNT,
  parameter logic [CNT_W-1:0] ONE_HIGH_LEN = ONE_HIGH_CNT,
  parameter logic [CNT_W-1:0] END_LOW_LEN = END_LOW_CNT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  htl_if.sensor link,
  input wire logic meas_done,
  input wire logic [BYTE_W-1:0] meas_hum,
  input wire logic [BYTE_W-1:0] meas_temp,
  output logic meas_req,
  output logic active,
  output logic sending
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    htl_sen_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [5:0] nbit;
    logic [FRAME_BITS-1:0] sh;
    logic [BYTE_W-1:0] hum;
    logic [BYTE_W-1:0] temp;
    logic oe;
    logic meas_req;
    logic active;
  } htl_sen_regs_t;

  htl_sen_regs_t s;
  htl_sen_regs_t next_s;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] high_len;
  logic [BYTE_W-1:0] csum;
  logic [FRAME_BITS-1:0] frame;

  // ----------------------------------------------------------------
  // Frame assembly from the stored sample
  // ----------------------------------------------------------------
  assign csum = s.hum + FRAC_BYTE + s.temp + FRAC_BYTE;
  assign frame = {s.hum, FRAC_BYTE, s.temp, FRAC_BYTE, csum};
  assign cnt_inc = s.cnt + CNT_W'(1);
  assign high_len = s.sh[FRAME_BITS-1] ? ONE_HIGH_LEN : ZERO_HIGH_LEN;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.meas_req = 1'b0;
    next_s.cnt = cnt_inc;
    unique case (s.st)
      SEN_MEAS: begin
        // Sample is taken while the line floats high
        next_s.oe = 1'b0;
        if (meas_done) begin
          next_s.hum = meas_hum;
          next_s.temp = meas_temp;
          next_s.st = SEN_IDLE;
          next_s.active = 1'b0;
        end
      end
      SEN_IDLE: begin
        next_s.oe = 1'b0;
        if (!link.line) begin
          next_s.st = SEN_LOWCNT;
          next_s.cnt = CNT_W'(1);
          next_s.active = 1'b1;
        end
      end
      SEN_LOWCNT: begin
        if (link.line) begin
          // Short pulses are glitches or a broken start
          if (s.cnt >= START_MIN) begin
            next_s.st = SEN_GAP;
            next_s.cnt = '0;
          end else begin
            next_s.st = SEN_IDLE;
            next_s.active = 1'b0;
          end
        end else if (s.cnt == START_MIN) begin
          next_s.cnt = s.cnt; // Saturate, long holds still count
        end
      end
      SEN_GAP: begin
        if (!link.line) begin
          next_s.st = SEN_IDLE;
          next_s.active = 1'b0;
        end else if (s.cnt == GAP_LEN - CNT_W'(1)) begin
          next_s.st = SEN_RLOW;
          next_s.cnt = '0;
          next_s.oe = 1'b1;
          next_s.sh = frame;
        end
      end
      SEN_RLOW: begin
        if (s.cnt == RESP_LEN - CNT_W'(1)) begin
          next_s.st = SEN_RHIGH;
          next_s.cnt = '0;
          next_s.oe = 1'b0;
        end
      end
      SEN_RHIGH: begin
        if (s.cnt == RESP_LEN - CNT_W'(1)) begin
          next_s.st = SEN_BLOW;
          next_s.cnt = '0;
          next_s.oe = 1'b1;
          next_s.nbit = '0;
        end
      end
      SEN_BLOW: begin
        if (s.cnt == BIT_LOW_LEN - CNT_W'(1)) begin
          next_s.st = SEN_BHIGH;
          next_s.cnt = '0;
          next_s.oe = 1'b0;
        end
      end
      SEN_BHIGH: begin
        if (s.cnt == high_len - CNT_W'(1)) begin
          next_s.cnt = '0;
          next_s.oe = 1'b1;
          next_s.sh = {s.sh[FRAME_BITS-2:0], 1'b0};
          if (s.nbit == LAST_BIT) begin
            next_s.st = SEN_ELOW;
          end else begin
            next_s.st = SEN_BLOW;
            next_s.nbit = s.nbit + 6'h01;
          end
        end
      end
      SEN_ELOW: begin
        if (s.cnt == END_LOW_LEN - CNT_W'(1)) begin
          next_s.st = SEN_MEAS;
          next_s.cnt = '0;
          next_s.oe = 1'b0;
          next_s.meas_req = 1'b1;
        end
      end
      default: begin
        // Unused codes fall back to a released line
        next_s.st = SEN_IDLE;
        next_s.oe = 1'b0;
        next_s.active = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      next_s_reset_guard: begin
        s.st <= SEN_MEAS;
        s.cnt <= '0;
        s.nbit <= '0;
        s.sh <= '0;
        s.hum <= 8'h00;
        s.temp <= 8'h00;
        s.oe <= 1'b0;
        s.meas_req <= 1'b1;
        s.active <= 1'b1;
      end
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Pin and status outputs
  // ----------------------------------------------------------------
  // Output value is always low; only the enable moves
  assign link.sens_out = 1'b0;
  assign link.sens_oe = s.oe;
  assign meas_req = s.meas_req;
  assign active = s.active;
  assign sending = s.oe;

endmodule
`default_nettype wire

// *** htl_pkg.sv ***
// Shared constants, types and state encodings for the single-wire sensor link
package htl_pkg;

  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int CNT_W = 28;
  localparam int BYTE_W = 8;
  localparam int FRAME_BITS = 40;
  localparam logic [5:0] LAST_BIT = 6'(FRAME_BITS - 1);
  localparam logic [BYTE_W-1:0] FRAC_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Times as printed
  // ----------------------------------------------------------------
  localparam int START_MS = 18;
  localparam int SETTLE_MS = 1000;
  localparam int HOLD_MS = 5000;
  localparam int TMO_US = 200;
  localparam int GAP_US = 30;
  localparam int RESP_US = 80;
  localparam int BIT_LOW_US = 50;
  localparam int ZERO_HIGH_US = 27;
  localparam int ONE_HIGH_US = 70;
  localparam int END_LOW_US = 50;
  localparam int THRESH_US = 50;

  // ----------------------------------------------------------------
  // Cycle counts at the system clock
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] START_CNT = CNT_W'(START_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] TMO_CNT = CNT_W'(TMO_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] RESP_CNT = CNT_W'(RESP_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] BIT_LOW_CNT = CNT_W'(BIT_LOW_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ZERO_HIGH_CNT = CNT_W'(ZERO_HIGH_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ONE_HIGH_CNT = CNT_W'(ONE_HIGH_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] END_LOW_CNT = CNT_W'(END_LOW_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] THRESH_CNT = CNT_W'(THRESH_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEN_MEAS = 4'h0,
    SEN_IDLE = 4'h1,
    SEN_LOWCNT = 4'h3,
    SEN_GAP = 4'h2,
    SEN_RLOW = 4'h6,
    SEN_RHIGH = 4'h7,
    SEN_BLOW = 4'h5,
    SEN_BHIGH = 4'h4,
    SEN_ELOW = 4'hC
  } htl_sen_state_t;

  typedef enum logic [3:0] {
    HST_PWR = 4'h0,
    HST_IDLE = 4'h1,
    HST_START = 4'h3,
    HST_REL = 4'h2,
    HST_ACKL = 4'h6,
    HST_ACKH = 4'h7,
    HST_BLOW = 4'h5,
    HST_BHIGH = 4'h4,
    HST_ELOW = 4'hC,
    HST_HOLD = 4'hD
  } htl_hst_state_t;

  function automatic logic [BYTE_W-1:0] htl_sum(input logic [FRAME_BITS-1:0] f);
    htl_sum = f[39:32] + f[31:24] + f[23:16] + f[15:8];
  endfunction

endpackage

// *** htl_if.sv ***
// Open-drain data line shared by host and sensor
`timescale 1ns/1ps
`default_nettype none
interface htl_if;
  logic host_out;
  logic host_oe;
  logic sens_out;
  logic sens_oe;
  logic line;

  // ----------------------------------------------------------------
  // Wired-AND with pull-up: high unless someone pulls low
  // ----------------------------------------------------------------
  assign line = ~((host_oe & ~host_out) | (sens_oe & ~sens_out));

  modport host (input line, output host_out, output host_oe);
  modport sensor (input line, output sens_out, output sens_oe);
endinterface
`default_nettype wire

// *** htl_host.sv ***
// Host end of the single-wire link: start pulse, frame capture, checksum check
`timescale 1ns/1ps
`default_nettype none
module htl_host
  import htl_pkg::*;
#(
  parameter logic [CNT_W-1:0] START_LEN = START_CNT,
  parameter logic [CNT_W-1:0] SETTLE_LEN = SETTLE_CNT,
  parameter logic [CNT_W-1:0] HOLD_LEN = HOLD_CNT,
  parameter logic [CNT_W-1:0] TMO_LEN = TMO_CNT,
  parameter logic [CNT_W-1:0] THRESH_LEN = THRESH_CNT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  htl_if.host link,
  input wire logic rd_req,
  output logic busy,
  output logic rd_valid,
  output logic rd_err,
  output logic [BYTE_W-1:0] rd_hum,
  output logic [BYTE_W-1:0] rd_temp
);

  typedef struct packed {
    htl_hst_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [5:0] nbit;
    logic [FRAME_BITS-1:0] sh;
    logic oe;
    logic retry;
    logic busy;
    logic valid;
    logic err;
    logic [BYTE_W-1:0] hum;
    logic [BYTE_W-1:0] temp;
  } htl_hst_regs_t;

  htl_hst_regs_t s;
  htl_hst_regs_t next_s;
  logic waiting;
  logic timed_out;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign waiting = (s.st == HST_REL) || (s.st == HST_ACKL) || (s.st == HST_ACKH) ||
                   (s.st == HST_BLOW) || (s.st == HST_BHIGH) || (s.st == HST_ELOW);
  assign timed_out = waiting && (s.cnt == TMO_LEN);

  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.err = 1'b0;
    next_s.cnt = s.cnt + CNT_W'(1);
    if (timed_out) begin
      next_s.st = HST_HOLD;
      next_s.cnt = '0;
      next_s.err = 1'b1;
      next_s.retry = 1'b1;
    end else begin
      unique case (s.st)
        HST_PWR: begin
          if (s.cnt == SETTLE_LEN) begin
            next_s.st = HST_IDLE;
            next_s.busy = 1'b0;
          end
        end
        HST_IDLE: begin
          if (rd_req) begin
            next_s.st = HST_START;
            next_s.cnt = '0;
            next_s.oe = 1'b1;
            next_s.busy = 1'b1;
          end
        end
        HST_START: begin
          if (s.cnt == START_LEN - CNT_W'(1)) begin
            next_s.st = HST_REL;
            next_s.cnt = '0;
            next_s.oe = 1'b0;
          end
        end
        HST_REL: begin
          if (!link.line) begin
            next_s.st = HST_ACKL;
            next_s.cnt = '0;
          end
        end
        HST_ACKL: begin
          if (link.line) begin
            next_s.st = HST_ACKH;
            next_s.cnt = '0;
          end
        end
        HST_ACKH: begin
          if (!link.line) begin
            next_s.st = HST_BLOW;
            next_s.cnt = '0;
            next_s.nbit = '0;
          end
        end
        HST_BLOW: begin
          if (link.line) begin
            next_s.st = HST_BHIGH;
            next_s.cnt = '0;
          end
        end
        HST_BHIGH: begin
          if (!link.line) begin
            next_s.cnt = '0;
            next_s.sh = {s.sh[FRAME_BITS-2:0], (s.cnt >= THRESH_LEN)};
            next_s.nbit = s.nbit + 6'h01;
            next_s.st = (s.nbit == LAST_BIT) ? HST_ELOW : HST_BLOW;
          end
        end
        HST_ELOW: begin
          if (link.line) begin
            next_s.st = HST_HOLD;
            next_s.cnt = '0;
            if (htl_sum(s.sh) == s.sh[7:0]) begin
              next_s.valid = 1'b1;
              next_s.hum = s.sh[39:32];
              next_s.temp = s.sh[23:16];
              next_s.retry = 1'b0;
            end else begin
              next_s.err = 1'b1;
              next_s.retry = 1'b1;
            end
          end
        end
        HST_HOLD: begin
          // Spacing protects the sensor's sampling period
          if (s.cnt == HOLD_LEN) begin
            next_s.cnt = '0;
            if (s.retry) begin
              next_s.st = HST_START;
              next_s.oe = 1'b1;
            end else begin
              next_s.st = HST_IDLE;
              next_s.busy = 1'b0;
            end
          end
        end
        default: begin
          next_s.st = HST_IDLE;
          next_s.oe = 1'b0;
          next_s.busy = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: HST_PWR, busy: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.host_out = 1'b0;
  assign link.host_oe = s.oe;
  assign busy = s.busy;
  assign rd_valid = s.valid;
  assign rd_err = s.err;
  assign rd_hum = s.hum;
  assign rd_temp = s.temp;

endmodule
`default_nettype wire

// *** htl_link_props.sv ***
// Checker for the shared line between the host and sensor ends
`timescale 1ns/1ps
`default_nettype none
module htl_link_props
  import htl_pkg::*;
#(
  parameter logic [CNT_W-1:0] START_LEN = START_CNT,
  parameter logic [CNT_W-1:0] SETTLE_LEN = SETTLE_CNT,
  parameter logic [CNT_W-1:0] HOLD_LEN = HOLD_CNT,
  parameter logic [CNT_W-1:0] GAP_LEN = GAP_CNT,
  parameter logic [CNT_W-1:0] RESP_LEN = RESP_CNT,
  parameter logic [CNT_W-1:0] BIT_LOW_LEN = BIT_LOW_CNT,
  parameter logic [CNT_W-1:0] ZERO_HIGH_LEN = ZERO_HIGH_CNT,
  parameter logic [CNT_W-1:0] ONE_HIGH_LEN = ONE_HIGH_CNT,
  parameter logic [CNT_W-1:0] END_LOW_LEN = END_LOW_CNT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic sens_out,
  input wire logic sens_oe,
  input wire logic line
);
  // ------------------------------
  // Phase counters
  // ------------------------------
  logic [CNT_W-1:0] hlen, drv, rel, age;
  logic [5:0] rises;
  logic done;
  logic ans_wait;
  logic [CNT_W-1:0] ans;

  // Rises start at 42 so a reply nobody asked for shows at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hlen <= '0;
      drv <= '0;
      rel <= '0;
      age <= '0;
      rises <= 6'h2A;
      done <= 1'b0;
      ans_wait <= 1'b0;
      ans <= '0;
    end else begin
      hlen <= host_oe ? hlen + 1'b1 : '0;
      drv <= sens_oe ? drv + 1'b1 : '0;
      rel <= sens_oe ? '0 : rel + 1'b1;
      age <= age + 1'b1;
      if ($fell(host_oe)) begin
        rises <= 6'h00;
      end else if ($rose(sens_oe)) begin
        rises <= rises + 6'h01;
      end
      if ($fell(sens_oe) && rises == 6'h2A) begin
        done <= 1'b1;
      end
      // Reply gap is too long for a delay range, so it is counted
      if ($fell(host_oe)) begin
        ans_wait <= 1'b1;
        ans <= '0;
      end else if ($rose(sens_oe)) begin
        ans_wait <= 1'b0;
      end else if (ans_wait) begin
        ans <= ans + 1'b1;
      end
    end
  end

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_release;
    $fell(host_oe);
  endsequence
  sequence s_answer;
    ans_wait && $rose(sens_oe);
  endsequence

  AST_OPEN_DRAIN: assert property (!host_out && !sens_out)
    else $error("pin driven high");
  AST_ONE_DRIVER: assert property (!(host_oe && sens_oe))
    else $error("both ends pull low");
  AST_IDLE_HIGH: assert property ((!host_oe && !sens_oe) |-> line)
    else $error("released line not high");
  AST_NO_SELF_START: assert property ($rose(sens_oe) |-> rises < 6'h2A)
    else $error("sensor pulls low unasked");
  AST_ANSWER: assert property (ans_wait |-> ans <= GAP_LEN)
    else $error("no response after start");
  AST_GAP: assert property (s_answer |-> ans == GAP_LEN)
    else $error("response at wrong time");
  AST_LOW_LEN: assert property ($fell(sens_oe) |->
    drv == ((rises == 6'h01) ? RESP_LEN : (rises == 6'h2A) ? END_LOW_LEN : BIT_LOW_LEN))
    else $error("bad low length");
  AST_RESP_HIGH: assert property (($rose(sens_oe) && rises == 6'h01) |-> rel == RESP_LEN)
    else $error("bad response high length");
  AST_BIT_HIGH: assert property (($rose(sens_oe) && rises > 6'h01 && rises < 6'h2A)
    |-> (rel == ZERO_HIGH_LEN || rel == ONE_HIGH_LEN)) else $error("bad bit high length");
  AST_START: assert property (s_release |-> hlen >= START_LEN)
    else $error("start pulse too short");
  AST_SETTLE: assert property ($rose(host_oe) |-> age >= SETTLE_LEN)
    else $error("start before settling");
  AST_HOLD: assert property (($rose(host_oe) && done) |-> rel >= HOLD_LEN)
    else $error("reads too close");
endmodule
`default_nettype wire

// *** testbench.sv ***
// Testbench: host and sensor ends joined, plus a lone sensor under a rogue host
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import htl_pkg::*;
  localparam logic [CNT_W-1:0] T_START = 28'h64;
  localparam logic [CNT_W-1:0] T_SETTLE = 28'h32;
  localparam logic [CNT_W-1:0] T_HOLD = 28'hC8;
  // Link times shortened tenfold to keep the run short
  localparam logic [CNT_W-1:0] T_GAP = 28'h96;
  localparam logic [CNT_W-1:0] T_RESP = 28'h190;
  localparam logic [CNT_W-1:0] T_BLOW = 28'hFA;
  localparam logic [CNT_W-1:0] T_ZERO = 28'h87;
  localparam logic [CNT_W-1:0] T_ONE = 28'h15E;
  localparam logic [CNT_W-1:0] T_END = 28'hFA;
  localparam logic [CNT_W-1:0] T_THRESH = 28'hFA;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic rd_req = 1'b0;
  logic meas_done = 1'b0;
  logic [7:0] meas_hum = 8'h00;
  logic [7:0] meas_temp = 8'h00;
  logic meas_req, active, sending, busy, rd_valid, rd_err, active_b, go;
  logic [7:0] rd_hum, rd_temp, cur_h, cur_t, want_h, want_t;
  logic [39:0] f;
  logic oe_d = 1'b0;
  logic last = 1'b1;
  logic pend = 1'b1;
  int seed = 23;
  int num_errors = 0;
  int n_compared = 0;
  int n_err = 0;
  int nmeas = 0;
  int run = 0;
  int ph[$];

  htl_if lnk();
  htl_if lnk_b();

  htl_host #(.START_LEN(T_START), .SETTLE_LEN(T_SETTLE), .HOLD_LEN(T_HOLD),
    .THRESH_LEN(T_THRESH)) htl_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(lnk), .rd_req(rd_req), .busy(busy),
    .rd_valid(rd_valid), .rd_err(rd_err), .rd_hum(rd_hum), .rd_temp(rd_temp));
  htl_sensor #(.START_MIN(T_START), .GAP_LEN(T_GAP), .RESP_LEN(T_RESP), .BIT_LOW_LEN(T_BLOW),
    .ZERO_HIGH_LEN(T_ZERO), .ONE_HIGH_LEN(T_ONE), .END_LOW_LEN(T_END)) htl_sensor_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(lnk), .meas_done(meas_done),
    .meas_hum(meas_hum), .meas_temp(meas_temp), .meas_req(meas_req), .active(active),
    .sending(sending));
  // Second sensor faces a host that breaks the start sequence on purpose in two of its three tries
  htl_sensor #(.START_MIN(T_START), .GAP_LEN(T_GAP), .RESP_LEN(T_RESP), .BIT_LOW_LEN(T_BLOW),
    .ZERO_HIGH_LEN(T_ZERO), .ONE_HIGH_LEN(T_ONE), .END_LOW_LEN(T_END)) htl_sensor_inst_b (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(lnk_b), .meas_done(meas_done),
    .meas_hum(meas_hum), .meas_temp(meas_temp), .meas_req(), .active(active_b),
    .sending());
  htl_link_props #(.START_LEN(T_START), .SETTLE_LEN(T_SETTLE), .HOLD_LEN(T_HOLD),
    .GAP_LEN(T_GAP), .RESP_LEN(T_RESP), .BIT_LOW_LEN(T_BLOW), .ZERO_HIGH_LEN(T_ZERO),
    .ONE_HIGH_LEN(T_ONE), .END_LOW_LEN(T_END))
    htl_link_props_inst (.clk_sys(clk_sys), .rst_n(rst_n), .host_out(lnk.host_out),
    .host_oe(lnk.host_oe), .sens_out(lnk.sens_out), .sens_oe(lnk.sens_oe), .line(lnk.line));

  always #10 clk_sys = ~clk_sys;

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [39:0] frame_of(input logic [7:0] h, input logic [7:0] t);
    logic [8:0] s;
    s = {1'b0, h} + {1'b0, t};
    frame_of = {h, 8'h00, t, 8'h00, s[7:0]};
  endfunction

  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Rogue start: pulse low, optional glitch in the gap, then look for a reply
  task automatic rogue(input int len, input logic glitch, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (200) @(posedge clk_sys);
    lnk_b.host_oe <= 1'b1;
    repeat (len) @(posedge clk_sys);
    lnk_b.host_oe <= 1'b0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk_sys);
      lnk_b.host_oe <= glitch && i >= 50 && i < 60;
      seen = seen | (lnk_b.sens_oe === 1'b1);
    end
    chk(seen, exp);
    chk(active_b, exp);
  endtask

  task automatic read_one(input logic stop);
    for (int i = 0; i < 40000 && rd_valid !== 1'b1; i++) @(posedge clk_sys);
    if (stop) rd_req <= 1'b0;
    f = frame_of(want_h, want_t);
    chk({rd_valid, rd_hum, rd_temp}, {1'b1, want_h, want_t});
    chk(busy, 1'b1);
    repeat (2) @(posedge clk_sys);
    chk(lnk.line, 1'b1);
    chk(sending, 1'b0);
    chk(ph.size(), 85);
    if (ph.size() == 85) begin
      chk(ph[0], T_START);
      chk(ph[2], T_RESP);
      chk(ph[3], T_RESP);
      chk(ph[84], T_END);
      for (int i = 0; i < 40; i++) begin
        chk(ph[4 + 2 * i], T_BLOW);
        chk(ph[5 + 2 * i], f[39 - i] ? T_ONE : T_ZERO);
      end
    end
  endtask

  // ------------------------------
  // Measurement source and line monitor
  // ------------------------------
  // First sample is quick so the sensor is listening before the host starts
  always @(posedge clk_sys) begin
    go = pend && !meas_req && rst_n && ((($random(seed) & 7) == 0) || nmeas == 0);
    meas_done <= go;
    if (meas_req) begin
      pend <= 1'b1;
    end else if (go) begin
      cur_h = (nmeas == 0) ? 8'hFF : (nmeas == 1) ? 8'h00 : 8'($random(seed));
      cur_t = (nmeas == 0) ? 8'hFF : (nmeas == 1) ? 8'h01 : 8'($random(seed));
      meas_hum <= cur_h;
      meas_temp <= cur_t;
      pend <= 1'b0;
      nmeas++;
    end
  end

  always @(posedge clk_sys) begin
    oe_d <= lnk.host_oe;
    if (rd_err === 1'b1) n_err++;
    if (lnk.host_oe && !oe_d) begin
      want_h <= meas_hum;
      want_t <= meas_temp;
      ph.delete();
      run = 1;
    end else if (lnk.line !== last) begin
      ph.push_back(run);
      run = 1;
    end else run++;
    last = lnk.line;
  end

  // ------------------------------
  // Main sequence and watchdog
  // ------------------------------
  initial begin
    lnk_b.host_out = 1'b0;
    lnk_b.host_oe = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_req <= 1'b1;
    fork
      for (int k = 0; k < 3; k++) begin
        rogue(k == 0 ? int'(T_START) - 2 : int'(T_START), k == 1, k == 2);
      end
      for (int r = 0; r < 3; r++) begin
        read_one(r == 2);
      end
    join
    chk(n_err, 0);
    report_and_stop();
  end

  // Three frames of about 21k cycles each, with margin
  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
